// [logic/umh_pkg.sv]
// Constants, register map and state types for the subslot MAC header controller.
// Assumes a single 25 MHz clock and a synchronous active-high reset in every clocked user.
package umh_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses on the local register port)
	// ------------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_HDR      = 8'h04;
	localparam logic [7:0] REG_ADDR     = 8'h08;
	localparam logic [7:0] REG_SDU0     = 8'h0C;
	localparam logic [7:0] REG_SDU1     = 8'h10;
	localparam logic [7:0] REG_SDU2     = 8'h14;
	localparam logic [7:0] REG_STAT     = 8'h18;
	localparam logic [7:0] REG_RXHDR    = 8'h1C;
	localparam logic [7:0] REG_RXADDR   = 8'h20;

	// Status bit positions (bits 1, 2, 4, 5 are write-one-to-clear)
	localparam int ST_TX_BUSY = 0;
	localparam int ST_TX_DONE = 1;
	localparam int ST_TX_ERR  = 2;
	localparam int ST_RX_BUSY = 3;
	localparam int ST_RX_DONE = 4;
	localparam int ST_RX_ERR  = 5;

	// ------------------------------------------------------------------
	// Header geometry
	// ------------------------------------------------------------------
	localparam int         HDR_MAX    = 36;  // Longest header, bits
	localparam int         SDU_W      = 96;  // SDU holding registers, bits
	localparam logic [6:0] BLOCK_BITS = 7'h5C; // Subslot block capacity, 92 bits
	localparam logic [5:0] HDR_EL     = 6'h10; // 16
	localparam logic [5:0] HDR_24     = 6'h1E; // 30
	localparam logic [5:0] HDR_EL_OPT = 6'h16; // 22
	localparam logic [5:0] HDR_24_OPT = 6'h24; // 36
	localparam logic [6:0] SDU_EL     = 7'h4C; // 76
	localparam logic [6:0] SDU_24     = 7'h3E; // 62
	localparam logic [6:0] SDU_EL_OPT = 7'h46; // 70
	localparam logic [6:0] SDU_24_OPT = 7'h38; // 56
	localparam logic [5:0] OPT_IDX_EL = 6'h0F; // Index of optional-field flag, 10-bit address
	localparam logic [5:0] OPT_IDX_24 = 6'h1D; // Same, 24-bit address
	localparam logic [5:0] OPT_TAIL   = 6'h06; // Selector plus 5-bit field
	localparam logic [5:0] AT_IDX     = 6'h04; // Index of last address-type bit

	// Length indication codes
	localparam logic [4:0] LI_NULL = 5'h00;
	localparam logic [4:0] LI_MIN  = 5'h03;
	localparam logic [4:0] LI_MAX  = 5'h0C;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		CLS_DATA  = 2'h0,  // Data or resource
		CLS_FRAG  = 2'h1,  // End or fragment
		CLS_BCAST = 2'h2,  // Broadcast
		CLS_USIG  = 2'h3   // User-plane signalling
	} umh_class_t;

	typedef enum logic [1:0] {
		AT_SSI  = 2'h0,
		AT_EVT  = 2'h1,
		AT_USSI = 2'h2,
		AT_SMI  = 2'h3
	} umh_atype_t;

	localparam logic TYPE_ACCESS = 1'b0;
	localparam logic TYPE_ENDHU  = 1'b1;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_HDR  = 2'b01,
		TX_SDU  = 2'b11,
		TX_FILL = 2'b10
	} umh_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_HDR   = 2'b01,
		RX_SDU   = 2'b11,
		RX_CLASS = 2'b10
	} umh_rx_state_t;

endpackage

// [logic/umh_len_calc.sv]
// Header length and longest SDU of an uplink subslot access header.
// Assumes purely combinational use by the framer and the parser.
module umh_len_calc
	import umh_pkg::*;
(
	input  wire logic       evt_label_in,
	input  wire logic       opt_in,
	output logic [5:0]      hdr_len_out,
	output logic [6:0]      sdu_max_out
);

	// ------------------------------------------------------------------
	// Lookup by address width and optional fields
	// ------------------------------------------------------------------
	always_comb begin
		unique case ({evt_label_in, opt_in})
			2'b10: begin
				hdr_len_out = HDR_EL;
				sdu_max_out = SDU_EL;
			end
			2'b00: begin
				hdr_len_out = HDR_24;
				sdu_max_out = SDU_24;
			end
			2'b11: begin
				hdr_len_out = HDR_EL_OPT;
				sdu_max_out = SDU_EL_OPT;
			end
			2'b01: begin
				hdr_len_out = HDR_24_OPT;
				sdu_max_out = SDU_24_OPT;
			end
		endcase
	end

endmodule

// [logic/umh_ctrl.sv]
// Subslot MAC header controller: frames MAC-ACCESS PDUs towards the burst
// mapper and parses incoming headers, with a local register port.
// Assumes one 25 MHz clock, pins synchronous to it, no back-pressure.
//
// Overview of operation
// - On full-slot style channels two leading bits give the PDU class.
// - Mobile sends data PDUs uplink, base sends resource PDUs downlink.
// - Continuations go in fragment PDUs, final part in end PDUs.
// - Base broadcasts with three broadcast PDUs; both use user-plane signalling PDU.
// - On subslot channel first bit selects access (0) or end-HU (1).
// - Fill indication follows type; fill bits pad short SDUs.
// - SDU length equals PDU length minus header length.
// - Encryption flag covers only the SDU and holds for all fragments.
// - Address type picks kind; event label 10 bits, others 24.
// - Optional flag, then selector picks length indication or capacity request.
// - 5-bit length in octets; 0 null, 3 to 12 valid, rest reserved.
// - Null PDU ends after its length: 22 or 36 bits.
// - Null PDU is last in block, remainder filled.
// - Header and SDU limits 16/76, 30/62, 22/70, 36/56 bits.
// - Capacity request is fragmentation flag then 4-bit reservation field.
// - Never both length indication and capacity request.
// - Fields sent most significant bit first in listed order.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
module umh_ctrl
	import umh_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic [31:0]            reg_rdata_out,
	output logic                   tx_bit_out,
	output logic                   tx_valid_out,
	output logic                   tx_last_out,
	input  wire logic              rx_bit_in,
	input  wire logic              rx_valid_in,
	input  wire logic              rx_first_in,
	input  wire logic              rx_subslot_in,
	output logic                   rx_sdu_bit_out,
	output logic                   rx_sdu_valid_out
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [31:0]          hdr_cfg_ff;
	logic [23:0]          addr_cfg_ff;
	logic [SDU_W-1:0]     sdu_cfg_ff;
	logic [5:0]           stat_ff;
	logic [22:0]          rx_hdr_ff;
	logic [23:0]          rx_addr_ff;
	umh_tx_state_t        tx_st_ff;
	umh_rx_state_t        rx_st_ff;
	logic [HDR_MAX-1:0]   tx_hsh_ff;
	logic [SDU_W-1:0]     tx_ssh_ff;
	logic [6:0]           tx_pos_ff;
	logic [6:0]           tx_end_ff;
	logic [6:0]           tx_sdu_end_ff;
	logic [5:0]           tx_hlen_ff;
	logic                 tx_bit_ff;
	logic                 tx_valid_ff;
	logic                 tx_last_ff;
	logic [HDR_MAX-1:0]   rx_sh_ff;
	logic [5:0]           rx_pos_ff;
	logic                 rx_el_ff;
	logic                 rx_opt_ff;
	logic [6:0]           rx_left_ff;
	logic                 rx_sbit_ff;
	logic                 rx_svalid_ff;
	logic [31:0]          rdata_ff;
	logic                 tx_start;
	logic                 tx_fin;
	logic                 tx_bad;
	logic                 rx_fin;
	logic                 rx_bad;

	// Configuration fields
	logic       c_enc;
	logic [1:0] c_at;
	logic       c_opt;
	logic       c_sel;
	logic [4:0] c_li;
	logic       c_frag;
	logic [3:0] c_rr;
	logic       c_pend;
	logic [6:0] c_sdu_len;
	assign c_enc     = hdr_cfg_ff[0];
	assign c_at      = hdr_cfg_ff[2:1];
	assign c_opt     = hdr_cfg_ff[3];
	assign c_sel     = hdr_cfg_ff[4];
	assign c_li      = hdr_cfg_ff[9:5];
	assign c_frag    = hdr_cfg_ff[10];
	assign c_rr      = hdr_cfg_ff[14:11];
	assign c_pend    = hdr_cfg_ff[15];
	assign c_sdu_len = hdr_cfg_ff[22:16];

	// ------------------------------------------------------------------
	// Framer header assembly
	// ------------------------------------------------------------------
	logic               t_opt;
	logic               t_sel;
	logic               t_is_li;
	logic               t_null;
	logic               t_el;
	logic               t_fill;
	logic [4:0]         t_tail;
	logic [5:0]         t_hlen;
	logic [6:0]         t_smax;
	logic [7:0]         t_end;
	logic [7:0]         t_sdu_end;
	logic [6:0]         t_sdu_cnt;
	logic [HDR_MAX-1:0] t_hvec;

	// Pending signalling forces a capacity request, which excludes a length
	assign t_opt     = c_opt | c_pend;
	assign t_sel     = c_sel | c_pend;
	assign t_is_li   = t_opt & ~t_sel;
	assign t_null    = t_is_li & (c_li == LI_NULL);
	assign t_el      = (c_at == AT_EVT);
	assign t_tail    = t_sel ? {c_frag, c_rr} : c_li;
	assign t_sdu_cnt = t_null ? 7'h00 : c_sdu_len;
	// Null, plain and capacity-request PDUs run to block end; a length bounds the rest
	assign t_end     = (t_is_li && !t_null) ? {c_li, 3'b000} : {1'b0, BLOCK_BITS};
	assign t_sdu_end = {2'b00, t_hlen} + {1'b0, t_sdu_cnt};
	assign t_fill    = (t_sdu_end < t_end);

	umh_len_calc u_tx_len (
		.evt_label_in (t_el),
		.opt_in       (t_opt),
		.hdr_len_out  (t_hlen),
		.sdu_max_out  (t_smax)
	);

	// Left-aligned header, sent from the top bit down
	always_comb begin
		if (t_el) begin
			t_hvec = {TYPE_ACCESS, t_fill, c_enc, c_at, addr_cfg_ff[9:0],
				t_opt, t_sel, t_tail, 14'h0000};
		end else begin
			t_hvec = {TYPE_ACCESS, t_fill, c_enc, c_at, addr_cfg_ff,
				t_opt, t_sel, t_tail};
		end
	end

	// Reserved lengths, oversize SDUs and lengths below the header are refused
	assign tx_bad = (t_is_li && !t_null && (c_li < LI_MIN || c_li > LI_MAX))
		|| (t_sdu_cnt > t_smax)
		|| (t_sdu_end > t_end);
	assign tx_start = reg_wr_in && (reg_addr_in == REG_CTRL) && reg_wdata_in[0]
		&& (tx_st_ff == TX_IDLE);
	assign tx_fin = (tx_st_ff != TX_IDLE) && (tx_pos_ff == tx_end_ff - 7'h01);

	// ------------------------------------------------------------------
	// Framer state and serialiser
	// ------------------------------------------------------------------
	logic [6:0] tx_pos_nx;
	assign tx_pos_nx = tx_pos_ff + 7'h01;

	// Region walk: header, then SDU, then fill bits up to the end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_st_ff <= TX_IDLE;
		end else if (tx_start && !tx_bad) begin
			tx_st_ff <= TX_HDR;
		end else if (tx_fin) begin
			tx_st_ff <= TX_IDLE;
		end else if (tx_st_ff != TX_IDLE && tx_pos_nx == {1'b0, tx_hlen_ff}) begin
			tx_st_ff <= (tx_sdu_end_ff > tx_pos_nx) ? TX_SDU : TX_FILL;
		end else if (tx_st_ff == TX_SDU && tx_pos_nx == tx_sdu_end_ff) begin
			tx_st_ff <= TX_FILL;
		end
	end

	// Shift registers, bit position and frame limits
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_hsh_ff     <= '0;
			tx_ssh_ff     <= '0;
			tx_pos_ff     <= 7'h00;
			tx_end_ff     <= 7'h00;
			tx_sdu_end_ff <= 7'h00;
			tx_hlen_ff    <= 6'h00;
		end else if (tx_start) begin
			tx_hsh_ff     <= t_hvec;
			tx_ssh_ff     <= sdu_cfg_ff;
			tx_pos_ff     <= 7'h00;
			tx_end_ff     <= t_end[6:0];
			tx_sdu_end_ff <= t_sdu_end[6:0];
			tx_hlen_ff    <= t_hlen;
		end else if (tx_st_ff != TX_IDLE) begin
			tx_pos_ff <= tx_pos_nx;
			if (tx_st_ff == TX_HDR) begin
				tx_hsh_ff <= {tx_hsh_ff[HDR_MAX-2:0], 1'b0};
			end
			if (tx_st_ff == TX_SDU) begin
				tx_ssh_ff <= {tx_ssh_ff[SDU_W-2:0], 1'b0};
			end
		end
	end

	// Bit stream to the burst mapper; fill is a one then zeros
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_bit_ff   <= 1'b0;
			tx_valid_ff <= 1'b0;
			tx_last_ff  <= 1'b0;
		end else begin
			tx_valid_ff <= (tx_st_ff != TX_IDLE);
			tx_last_ff  <= tx_fin;
			unique case (tx_st_ff)
				TX_IDLE: tx_bit_ff <= 1'b0;
				TX_HDR:  tx_bit_ff <= tx_hsh_ff[HDR_MAX-1];
				TX_SDU:  tx_bit_ff <= tx_ssh_ff[SDU_W-1];
				TX_FILL: tx_bit_ff <= (tx_pos_ff == tx_sdu_end_ff);
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Parser
	// ------------------------------------------------------------------
	logic [HDR_MAX-1:0] r_sh_nx;
	logic [5:0]         r_opt_idx;
	logic               r_hdr_done;
	logic [5:0]         r_hlen;
	logic [6:0]         r_smax;
	logic [HDR_MAX-1:0] r_al;
	logic               r_el_now;
	logic               r_is_li;
	logic               r_null;
	logic [7:0]         r_pdu;
	logic [7:0]         r_sdu;
	logic [4:0]         r_tail;
	logic               r_opt;
	logic               r_sel;
	logic [23:0]        r_addr;

	assign r_sh_nx    = {rx_sh_ff[HDR_MAX-2:0], rx_bit_in};
	assign r_opt_idx  = rx_el_ff ? OPT_IDX_EL : OPT_IDX_24;
	assign r_hdr_done = rx_valid_in && (rx_st_ff == RX_HDR)
		&& (((rx_pos_ff == r_opt_idx) && !rx_bit_in)
		|| (rx_opt_ff && (rx_pos_ff == r_opt_idx + OPT_TAIL)));

	umh_len_calc u_rx_len (
		.evt_label_in (rx_el_ff),
		.opt_in       (rx_opt_ff),
		.hdr_len_out  (r_hlen),
		.sdu_max_out  (r_smax)
	);

	// Align the finished header to the framer layout, then pick fields
	assign r_al     = r_sh_nx << (6'(HDR_MAX) - r_hlen);
	assign r_el_now = (r_al[32:31] == AT_EVT);
	assign r_addr   = r_el_now ? {14'h0000, r_al[30:21]} : r_al[30:7];
	assign r_opt    = r_el_now ? r_al[20] : r_al[6];
	assign r_sel    = r_el_now ? r_al[19] : r_al[5];
	assign r_tail   = r_el_now ? r_al[18:14] : r_al[4:0];
	assign r_is_li  = r_opt & ~r_sel;
	assign r_null   = r_is_li & (r_tail == LI_NULL);
	assign r_pdu    = (r_is_li && !r_null) ? {r_tail, 3'b000} : {1'b0, BLOCK_BITS};
	assign r_sdu    = r_null ? 8'h00 : (r_pdu - {2'b00, r_hlen});
	assign rx_bad   = r_hdr_done && ((r_is_li && !r_null
		&& (r_tail < LI_MIN || r_tail > LI_MAX)) || (r_pdu < {2'b00, r_hlen}));
	assign rx_fin   = (r_hdr_done && (rx_bad || r_sdu == 8'h00))
		|| (rx_valid_in && rx_st_ff == RX_CLASS)
		|| (rx_valid_in && rx_first_in && rx_st_ff == RX_IDLE
			&& rx_subslot_in && rx_bit_in == TYPE_ENDHU)
		|| (rx_valid_in && rx_st_ff == RX_SDU && rx_left_ff == 7'h01);

	// Parser state: subslot type bit or two-bit class first
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_st_ff <= RX_IDLE;
		end else if (rx_valid_in) begin
			unique case (rx_st_ff)
				RX_IDLE: if (rx_first_in) begin
					if (!rx_subslot_in) begin
						rx_st_ff <= RX_CLASS;
					end else if (rx_bit_in == TYPE_ACCESS) begin
						rx_st_ff <= RX_HDR;
					end
				end
				RX_CLASS: rx_st_ff <= RX_IDLE;
				RX_HDR: if (r_hdr_done) begin
					rx_st_ff <= (rx_bad || r_sdu == 8'h00) ? RX_IDLE : RX_SDU;
				end
				RX_SDU: if (rx_left_ff == 7'h01) begin
					rx_st_ff <= RX_IDLE;
				end
			endcase
		end
	end

	// Header collection and captured fields
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_sh_ff   <= '0;
			rx_pos_ff  <= 6'h00;
			rx_el_ff   <= 1'b0;
			rx_opt_ff  <= 1'b0;
			rx_left_ff <= 7'h00;
			rx_hdr_ff  <= '0;
			rx_addr_ff <= '0;
		end else if (rx_valid_in) begin
			if (rx_st_ff == RX_IDLE && rx_first_in) begin
				rx_sh_ff  <= {{(HDR_MAX-1){1'b0}}, rx_bit_in};
				rx_pos_ff <= 6'h01;
				rx_el_ff  <= 1'b0;
				rx_opt_ff <= 1'b0;
				rx_hdr_ff <= '0;
				rx_hdr_ff[1:0] <= {rx_bit_in, 1'b0};
				rx_hdr_ff[2]   <= rx_subslot_in;
				rx_hdr_ff[3]   <= rx_subslot_in & (rx_bit_in == TYPE_ENDHU);
			end else if (rx_st_ff == RX_CLASS) begin
				rx_hdr_ff[0] <= rx_bit_in;
			end else if (rx_st_ff == RX_HDR) begin
				rx_sh_ff  <= r_sh_nx;
				rx_pos_ff <= rx_pos_ff + 6'h01;
				if (rx_pos_ff == AT_IDX) begin
					rx_el_ff <= ({rx_sh_ff[0], rx_bit_in} == AT_EVT);
				end
				if (rx_pos_ff == r_opt_idx) begin
					rx_opt_ff <= rx_bit_in;
				end
				if (r_hdr_done) begin
					rx_hdr_ff[4]     <= r_al[34];
					rx_hdr_ff[5]     <= r_al[33];
					rx_hdr_ff[7:6]   <= r_al[32:31];
					rx_hdr_ff[8]     <= r_opt;
					rx_hdr_ff[9]     <= r_sel;
					rx_hdr_ff[14:10] <= r_tail;
					rx_hdr_ff[15]    <= r_null;
					rx_hdr_ff[22:16] <= r_sdu[6:0];
					rx_addr_ff       <= r_addr;
					rx_left_ff       <= r_sdu[6:0];
				end
			end else if (rx_st_ff == RX_SDU) begin
				rx_left_ff <= rx_left_ff - 7'h01;
			end
		end
	end

	// SDU bits pass straight to the LLC side, header stripped
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_sbit_ff   <= 1'b0;
			rx_svalid_ff <= 1'b0;
		end else begin
			rx_sbit_ff   <= rx_bit_in;
			rx_svalid_ff <= rx_valid_in && (rx_st_ff == RX_SDU);
		end
	end

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	logic stat_wr;
	assign stat_wr = reg_wr_in && (reg_addr_in == REG_STAT);

	// Configuration writes
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			hdr_cfg_ff  <= '0;
			addr_cfg_ff <= '0;
			sdu_cfg_ff  <= '0;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				REG_HDR:  hdr_cfg_ff <= {9'h000, reg_wdata_in[22:0]};
				REG_ADDR: addr_cfg_ff <= reg_wdata_in[23:0];
				REG_SDU0: sdu_cfg_ff[95:64] <= reg_wdata_in;
				REG_SDU1: sdu_cfg_ff[63:32] <= reg_wdata_in;
				REG_SDU2: sdu_cfg_ff[31:0] <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Live busy bits and sticky done and error bits; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			stat_ff <= '0;
		end else begin
			stat_ff[ST_TX_BUSY] <= (tx_st_ff != TX_IDLE && !tx_fin) || (tx_start && !tx_bad);
			stat_ff[ST_RX_BUSY] <= (rx_st_ff != RX_IDLE && !rx_fin)
				|| (rx_valid_in && rx_first_in && rx_st_ff == RX_IDLE && !rx_fin);
			stat_ff[ST_TX_DONE] <= tx_fin
				|| (stat_ff[ST_TX_DONE] && !(stat_wr && reg_wdata_in[ST_TX_DONE]));
			stat_ff[ST_TX_ERR]  <= (tx_start && tx_bad)
				|| (stat_ff[ST_TX_ERR] && !(stat_wr && reg_wdata_in[ST_TX_ERR]));
			stat_ff[ST_RX_DONE] <= (rx_fin && !rx_bad)
				|| (stat_ff[ST_RX_DONE] && !(stat_wr && reg_wdata_in[ST_RX_DONE]));
			stat_ff[ST_RX_ERR]  <= rx_bad
				|| (stat_ff[ST_RX_ERR] && !(stat_wr && reg_wdata_in[ST_RX_ERR]));
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_ff <= '0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_HDR:    rdata_ff <= hdr_cfg_ff;
				REG_ADDR:   rdata_ff <= {8'h00, addr_cfg_ff};
				REG_SDU0:   rdata_ff <= sdu_cfg_ff[95:64];
				REG_SDU1:   rdata_ff <= sdu_cfg_ff[63:32];
				REG_SDU2:   rdata_ff <= sdu_cfg_ff[31:0];
				REG_STAT:   rdata_ff <= {26'h0000000, stat_ff};
				REG_RXHDR:  rdata_ff <= {9'h000, rx_hdr_ff};
				REG_RXADDR: rdata_ff <= {8'h00, rx_addr_ff};
				default:    rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata_out    = rdata_ff;
	assign tx_bit_out       = tx_bit_ff;
	assign tx_valid_out     = tx_valid_ff;
	assign tx_last_out      = tx_last_ff;
	assign rx_sdu_bit_out   = rx_sbit_ff;
	assign rx_sdu_valid_out = rx_svalid_ff;

endmodule

// [test/umh_ctrl_sva.sv]
// Port assertions for the subslot MAC header controller.
// Assumes a bind onto umh_ctrl with one clock and a synchronous reset.
module umh_ctrl_sva (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic tx_bit_out,
	input wire logic tx_valid_out,
	input wire logic tx_last_out,
	input wire logic rx_bit_in,
	input wire logic rx_valid_in,
	input wire logic rx_first_in,
	input wire logic rx_subslot_in,
	input wire logic rx_sdu_bit_out,
	input wire logic rx_sdu_valid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] tx_pos_ff;
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Position of the current bit within the outgoing frame
	always_ff @(posedge clk_in) begin
		if (srst_in || !tx_valid_out || tx_last_out) begin
			tx_pos_ff <= 7'h00;
		end else begin
			tx_pos_ff <= tx_pos_ff + 7'h01;
		end
	end
	// Header start and frame end steps
	sequence s_sub_start;
		rx_valid_in && rx_first_in && rx_subslot_in;
	endsequence
	sequence s_cls_start;
		rx_valid_in && rx_first_in && !rx_subslot_in;
	endsequence
	sequence s_frame_end;
		tx_valid_out ##1 !tx_valid_out;
	endsequence
	first_bit_a: assert property ($rose(tx_valid_out) |-> !tx_bit_out)
		else $error("frame does not open with a zero type bit");
	no_stall_a: assert property (tx_valid_out && !tx_last_out |=> tx_valid_out)
		else $error("frame stream broke before its last bit");
	last_end_a: assert property (tx_last_out |-> s_frame_end)
		else $error("frame continued past its last bit");
	frame_len_a: assert property (tx_last_out |-> tx_pos_ff == 7'h5B ||
		(tx_pos_ff[2:0] == 3'h7 && tx_pos_ff >= 7'h17 && tx_pos_ff <= 7'h5F))
		else $error("frame length is neither octets nor block size");
	sdu_pass_a: assert property (rx_sdu_valid_out |->
		$past(rx_valid_in) && rx_sdu_bit_out == $past(rx_bit_in))
		else $error("received payload bit not passed on one cycle later");
	class_quiet_a: assert property (s_cls_start |=> !rx_sdu_valid_out [*2])
		else $error("class decode produced payload");
	endhu_quiet_a: assert property (s_sub_start ##0 rx_bit_in |=> !rx_sdu_valid_out [*2])
		else $error("end type bit produced payload");
	hdr_quiet_a: assert property (s_sub_start ##0 !rx_bit_in |=> !rx_sdu_valid_out [*8])
		else $error("payload appeared inside the header");
endmodule
bind umh_ctrl umh_ctrl_sva chk (
	.clk_in, .srst_in, .tx_bit_out, .tx_valid_out, .tx_last_out, .rx_bit_in,
	.rx_valid_in, .rx_first_in, .rx_subslot_in, .rx_sdu_bit_out, .rx_sdu_valid_out
);

// [test/umh_mapper_model.sv]
// Burst mapper stand-in: collects sent frames and replays bit patterns.
// Assumes the controller's clock and reset; patterns held steady while sent.
module umh_mapper_model (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        tx_bit_in,
	input  wire logic        tx_valid_in,
	input  wire logic        play_in,
	input  wire logic        sub_in,
	input  wire logic [95:0] pat_in,
	input  wire logic [6:0]  plen_in,
	output logic             rx_bit_out,
	output logic             rx_valid_out,
	output logic             rx_first_out,
	output logic             rx_subslot_out,
	output logic [95:0]      cap_out,
	output logic [6:0]       cnt_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       vld_ff;
	logic [6:0] left_ff;
	// Collect each frame, first bit ends most significant
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			vld_ff  <= 1'b0;
			cap_out <= 96'h0;
			cnt_out <= 7'h00;
		end else begin
			vld_ff <= tx_valid_in;
			if (tx_valid_in) begin
				cap_out <= vld_ff ? {cap_out[94:0], tx_bit_in} : {95'h0, tx_bit_in};
				cnt_out <= vld_ff ? cnt_out + 7'h01 : 7'h01;
			end
		end
	end
	// Replay a pattern, type bit first; idle line toggles
	always_ff @(posedge clk_in) begin
		rx_subslot_out <= sub_in;
		if (srst_in) begin
			left_ff      <= 7'h00;
			rx_valid_out <= 1'b0;
			rx_first_out <= 1'b0;
			rx_bit_out   <= 1'b0;
		end else if (play_in) begin
			left_ff      <= plen_in - 7'h01;
			rx_valid_out <= 1'b1;
			rx_first_out <= 1'b1;
			rx_bit_out   <= pat_in[plen_in - 7'h01];
		end else begin
			left_ff      <= (left_ff != 7'h00) ? left_ff - 7'h01 : 7'h00;
			rx_valid_out <= (left_ff != 7'h00);
			rx_first_out <= 1'b0;
			rx_bit_out   <= (left_ff != 7'h00) ? pat_in[left_ff - 7'h01] : ~rx_bit_out;
		end
	end
endmodule

// [test/test_uplink_subslot_mac_header_codec.sv]
// Self-checking bench for the subslot MAC header controller.
// Assumes the mapper model on the serial side and the register port.
module test_uplink_subslot_mac_header_codec;
	import umh_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic        play = 1'b0, sub = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, d, st;
	logic        tx_bit_out, tx_valid_out, tx_last_out, rx_bit_in, rx_valid_in;
	logic        rx_first_in, rx_subslot_in, rx_sdu_bit_out, rx_sdu_valid_out;
	logic [95:0] pat = 96'h0, cap, e_c;
	logic [6:0]  plen = 7'h00, cnt;
	logic [95:0] sdu = {32'hC3A59E17, 32'h5A0FF0E1, 32'h87654321};
	int          fail_count = 0, samples_checked = 0, cyc = 0, sdu_n = 0;
	umh_ctrl uut (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .tx_bit_out, .tx_valid_out, .tx_last_out, .rx_bit_in, .rx_valid_in,
		.rx_first_in, .rx_subslot_in, .rx_sdu_bit_out, .rx_sdu_valid_out);
	umh_mapper_model bm (.clk_in, .srst_in, .tx_bit_in(tx_bit_out),
		.tx_valid_in(tx_valid_out), .play_in(play), .sub_in(sub), .pat_in(pat),
		.plen_in(plen), .rx_bit_out(rx_bit_in), .rx_valid_out(rx_valid_in),
		.rx_first_out(rx_first_in), .rx_subslot_out(rx_subslot_in), .cap_out(cap),
		.cnt_out(cnt));
	// ------------------------------------------------------------------
	// Clock, hang limit and payload counter
	// ------------------------------------------------------------------
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (sdu_n >= 0 && rx_sdu_valid_out === 1'b1) sdu_n++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	// Verdict and end of run
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Compare seen against expected
	task chk(input logic [95:0] seen, input logic [95:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Register port cycles
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	// Poll status until a masked bit shows
	task wt(input logic [31:0] m);
		for (int i = 0; i < 300; i++) begin
			rd(REG_STAT);
			if ((d & m) != 32'h0) break;
		end
	endtask
	// Send one frame and compare what the mapper collected
	task tx_run(input logic [31:0] h, input logic [31:0] a, input logic [95:0] e,
		input logic [6:0] n, input logic [2:0] s);
		wr(REG_HDR, h);
		wr(REG_ADDR, a);
		wr(REG_CTRL, 32'h1);
		wt(32'h6);
		chk(d[2:0], s);
		chk(cnt, n);
		chk(cap, e);
		wr(REG_STAT, 32'h36);
	endtask
	// Replay a pattern into the parser and read the parsed header
	task rx_run(input logic [95:0] p, input logic [6:0] n, input logic s);
		pat <= p;
		plen <= n;
		sub <= s;
		sdu_n = 0;
		@(posedge clk_in);
		play <= 1'b1;
		@(posedge clk_in);
		play <= 1'b0;
		wt(32'h30);
		st = d;
		rd(REG_RXHDR);
		wr(REG_STAT, 32'h30);
	endtask
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		rd(REG_STAT);
		chk(d, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40);
		chk(d, 32'h0);
		$display("test registers finished");
		wr(REG_SDU0, sdu[95:64]);
		wr(REG_SDU1, sdu[63:32]);
		wr(REG_SDU2, sdu[31:0]);
		tx_run(32'h004C0003, 32'h2A5, {5'h05, 10'h2A5, 1'b0, sdu[95:20]}, 7'h5C, 3'b010);
		e_c = {5'h08, 24'h9C3E71, 2'b10, 5'h05, 4'h8};
		tx_run(32'h000000A8, 32'h9C3E71, e_c, 7'h28, 3'b010);
		tx_run(32'h00000028, 32'h9C3E71, e_c, 7'h28, 3'b100);
		tx_run(32'h004D0002, 32'h2A5, e_c, 7'h28, 3'b100);
		tx_run(32'h0000000A, 32'h155, {5'h09, 10'h155, 7'h40, 1'b1, 69'h0}, 7'h5C, 3'b010);
		tx_run(32'h0038D406, 32'h9C3E71, {5'h03, 24'h9C3E71, 7'h7A, sdu[95:40]}, 7'h5C, 3'b010);
		$display("test framing finished");
		rx_run(cap, cnt, 1'b1);
		chk(d[22:2], {7'h38, 1'b0, 5'h1A, 2'b11, 2'b11, 4'h1});
		chk(sdu_n, 96'd56);
		rd(REG_RXADDR);
		chk(d, 32'h9C3E71);
		for (int c = 0; c < 4; c++) begin
			rx_run(96'(c), 7'h02, 1'b0);
			chk(d[1:0], c[1:0]);
		end
		rx_run(96'h1, 7'h01, 1'b1);
		chk(d[3], 1'b1);
		// Reserved length in a received header: error, no payload
		rx_run(96'h20041, 7'h16, 1'b1);
		chk(d[14:2], {5'h01, 2'b01, 2'b01, 4'h1});
		chk(st[5:3], 3'b100);
		chk(sdu_n, 0);
		$display("test parsing finished");
		conclude();
	end
endmodule
